//--- pus_pkg.sv
// Purpose: Shared constants and types of the power-up sequencer
// Assumes: 25 MHz system clock
// Notes:   Times are kept in microseconds and cycle counts derive from them
package pus_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned PUS_CLK_FREQ_MHZ = 25;
  localparam int unsigned PUS_INIT_TIME_US = 6000;
  localparam int unsigned PUS_STRAP_TIME_US = 2000;
  // Exact products, so the least-time round-up is already whole
  localparam int unsigned PUS_INIT_CYCLES = PUS_INIT_TIME_US * PUS_CLK_FREQ_MHZ;
  localparam int unsigned PUS_STRAP_CYCLES = PUS_STRAP_TIME_US * PUS_CLK_FREQ_MHZ;
  localparam int unsigned PUS_TIMER_W = 18;

  // ----------------------------------------------------------------
  // Strap and voltage setting codes
  // ----------------------------------------------------------------
  localparam logic [1:0] PUS_STRAP_RES_GND = 2'h0;
  localparam logic [1:0] PUS_STRAP_SHORT_GND = 2'h1;
  localparam logic [1:0] PUS_STRAP_SHORT_RAIL = 2'h2;
  localparam logic [1:0] PUS_STRAP_CAP_GND = 2'h3;

  localparam logic [1:0] PUS_HOST_1V5 = 2'h0;
  localparam logic [1:0] PUS_HOST_1V8 = 2'h1;
  localparam logic [1:0] PUS_HOST_2V5 = 2'h2;
  localparam logic [1:0] PUS_HOST_3V3 = 2'h3;

  localparam logic [1:0] PUS_BOOST_2V7 = 2'h0;
  localparam logic [1:0] PUS_BOOST_3V8 = 2'h1;
  localparam logic [1:0] PUS_BOOST_4V7 = 2'h2;

  localparam logic [1:0] PUS_HOST_RESET = PUS_HOST_1V5;
  localparam logic [1:0] PUS_BOOST_RESET = PUS_BOOST_3V8;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PUS_ST_OFF = 3'b000,
    PUS_ST_INIT = 3'b001,
    PUS_ST_BOOST_WAIT = 3'b010,
    PUS_ST_STRAP = 3'b011,
    PUS_ST_LOAD = 3'b100,
    PUS_ST_BOOST_WAIT2 = 3'b101,
    PUS_ST_HOST_WAIT = 3'b110,
    PUS_ST_ACTIVE = 3'b111
  } pus_state_t;

endpackage

//--- pus_timer.sv
// Purpose: Loadable down-counter giving a one-cycle done pulse
// Assumes: start_i is a one-cycle pulse; abort_i stops a running count
// Notes:   A load of zero is treated as one cycle
`timescale 1ns/1ps
`default_nettype none
module pus_timer #(
  parameter int unsigned W = 18
) (
  input wire logic clk_sys_i, // System clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic start_i, // Load and start
  input wire logic abort_i, // Stop counting
  input wire logic [W-1:0] load_i, // Cycles to count
  output logic done_o // Pulse when count ends
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic busy_q;
  logic busy_d;
  logic done_q;
  logic done_d;

  always_comb
  begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (abort_i)
    begin
      busy_d = 1'b0;
    end
    else if (start_i)
    begin
      cnt_d = (load_i == '0) ? W'(0) : W'(load_i - W'(1));
      busy_d = 1'b1;
    end
    else if (busy_q)
    begin
      if (cnt_q == '0)
      begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end
      else
      begin
        cnt_d = W'(cnt_q - W'(1));
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign done_o = done_q;

endmodule
`default_nettype wire

//--- pus_sequencer.sv
// Purpose: Power-up sequencer driving boost and host-supply regulator enables
// Assumes: Power-good and threshold inputs are synchronous to clk_sys_i
// Notes:   Strap input is the sensed connection code, sampled for a window
//
// Operation
// R1: Hold 6 ms initialisation after supply rises
// R2: Then enable boost at 3.8 V setting
// R3: Wait boost power-good before advancing
// R4: Sample strap 2 ms, then load settings
// R5: Strap decode gives host and boost voltages
// R6: Wait boost power-good again, then enable host
// R7: Enter active after host power-good
// R8: Same sequence when boost is unused
// R9: No timeout; supply loss returns to initialisation
`timescale 1ns/1ps
`default_nettype none
module pus_sequencer
  import pus_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = PUS_INIT_CYCLES,
  parameter int unsigned STRAP_CYCLES = PUS_STRAP_CYCLES
) (
  input wire logic clk_sys_i, // System clock, 25 MHz
  input wire logic rst_n_i, // Async reset, active low
  input wire logic power_up_threshold_i, // Supply above power-up threshold
  input wire logic boost_pg_i, // Boost power-good
  input wire logic host_pg_i, // Host-supply regulator power-good
  input wire logic [1:0] supply_select_strap_i, // Sensed strap code
  output logic boost_en_o, // Boost converter enable
  output logic [1:0] boost_voltage_setting_o, // Boost target code
  output logic host_supply_regulator_en_o, // Host regulator enable
  output logic [1:0] host_supply_voltage_setting_o, // Host target code
  output logic active_o, // Sequence complete
  output logic [2:0] state_o // Current state code
);

  // ----------------------------------------------------------------
  // Strap decode
  // ----------------------------------------------------------------
  function automatic logic [1:0] host_code(input logic [1:0] strap);
    logic [1:0] r;
    r = PUS_HOST_1V5;
    unique case (strap)
      PUS_STRAP_RES_GND: r = PUS_HOST_1V5;
      PUS_STRAP_SHORT_GND: r = PUS_HOST_1V8;
      PUS_STRAP_SHORT_RAIL: r = PUS_HOST_2V5;
      PUS_STRAP_CAP_GND: r = PUS_HOST_3V3;
    endcase
    return r;
  endfunction

  function automatic logic [1:0] boost_code(input logic [1:0] strap);
    logic [1:0] r;
    r = PUS_BOOST_2V7;
    unique case (strap)
      PUS_STRAP_RES_GND: r = PUS_BOOST_2V7;
      PUS_STRAP_SHORT_GND: r = PUS_BOOST_2V7;
      PUS_STRAP_SHORT_RAIL: r = PUS_BOOST_3V8;
      PUS_STRAP_CAP_GND: r = PUS_BOOST_4V7;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  pus_state_t state_q;
  pus_state_t state_d;
  logic boost_en_q;
  logic boost_en_d;
  logic [1:0] boost_set_q;
  logic [1:0] boost_set_d;
  logic host_en_q;
  logic host_en_d;
  logic [1:0] host_set_q;
  logic [1:0] host_set_d;
  logic [1:0] strap_q;
  logic [1:0] strap_d;
  logic active_q;
  logic active_d;
  logic tmr_start;
  logic tmr_abort;
  logic [PUS_TIMER_W-1:0] tmr_load;
  logic tmr_done;

  pus_timer #(
    .W(PUS_TIMER_W)
  ) u_timer (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .start_i(tmr_start),
    .abort_i(tmr_abort),
    .load_i(tmr_load),
    .done_o(tmr_done)
  );

  always_comb
  begin
    state_d = state_q;
    boost_en_d = boost_en_q;
    boost_set_d = boost_set_q;
    host_en_d = host_en_q;
    host_set_d = host_set_q;
    strap_d = strap_q;
    active_d = 1'b0;
    tmr_start = 1'b0;
    tmr_abort = 1'b0;
    tmr_load = PUS_TIMER_W'(INIT_CYCLES);
    if (!power_up_threshold_i)
    begin
      // Supply loss drops state, enables, settings and timer (strap_q keeps its value) and restarts from the top; see R9
      state_d = PUS_ST_OFF;
      boost_en_d = 1'b0;
      boost_set_d = PUS_BOOST_RESET;
      host_en_d = 1'b0;
      host_set_d = PUS_HOST_RESET;
      tmr_abort = 1'b1;
    end
    else
    begin
      unique case (state_q)
        PUS_ST_OFF:
        begin
          tmr_start = 1'b1; // see R1
          state_d = PUS_ST_INIT;
        end
        PUS_ST_INIT:
        begin
          if (tmr_done) // see R1
          begin
            boost_en_d = 1'b1; // see R2
            boost_set_d = PUS_BOOST_3V8; // see R2
            state_d = PUS_ST_BOOST_WAIT;
          end
        end
        PUS_ST_BOOST_WAIT:
        begin
          // Unused boost: external supply satisfies the check; see R8
          if (boost_pg_i) // see R3
          begin
            tmr_load = PUS_TIMER_W'(STRAP_CYCLES);
            tmr_start = 1'b1; // see R4
            state_d = PUS_ST_STRAP;
          end
        end
        PUS_ST_STRAP:
        begin
          strap_d = supply_select_strap_i; // see R4
          if (tmr_done)
          begin
            state_d = PUS_ST_LOAD;
          end
        end
        PUS_ST_LOAD:
        begin
          host_set_d = host_code(strap_q); // see R5
          boost_set_d = boost_code(strap_q); // see R5
          state_d = PUS_ST_BOOST_WAIT2;
        end
        PUS_ST_BOOST_WAIT2:
        begin
          // One cycle after load, so the comparator sees the new target
          if (boost_pg_i) // see R6
          begin
            host_en_d = 1'b1; // see R6
            state_d = PUS_ST_HOST_WAIT;
          end
        end
        PUS_ST_HOST_WAIT:
        begin
          if (host_pg_i) // see R7
          begin
            state_d = PUS_ST_ACTIVE;
            active_d = 1'b1;
          end
        end
        PUS_ST_ACTIVE:
        begin
          active_d = 1'b1; // see R7
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= PUS_ST_OFF;
      boost_en_q <= 1'b0;
      boost_set_q <= PUS_BOOST_RESET;
      host_en_q <= 1'b0;
      host_set_q <= PUS_HOST_RESET;
      strap_q <= PUS_STRAP_RES_GND;
      active_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      boost_en_q <= boost_en_d;
      boost_set_q <= boost_set_d;
      host_en_q <= host_en_d;
      host_set_q <= host_set_d;
      strap_q <= strap_d;
      active_q <= active_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  assign boost_en_o = boost_en_q;
  assign boost_voltage_setting_o = boost_set_q;
  assign host_supply_regulator_en_o = host_en_q;
  assign host_supply_voltage_setting_o = host_set_q;
  assign active_o = active_q;
  assign state_o = state_q;

endmodule
`default_nettype wire

//--- pus_sequencer_sva.sv
// Purpose: Port assertions for the power-up sequencer
// Assumes: One clock, async active-low reset
// Notes:   A dwell counter measures how long each state lasted
`timescale 1ns/1ps
`default_nettype none
module pus_sequencer_sva
  import pus_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = PUS_INIT_CYCLES,
  parameter int unsigned STRAP_CYCLES = PUS_STRAP_CYCLES
) (
  input wire logic clk_sys_i, // Clock
  input wire logic rst_n_i, // Reset
  input wire logic power_up_threshold_i, // Supply up
  input wire logic boost_pg_i, // Boost good
  input wire logic host_pg_i, // Host good
  input wire logic [1:0] supply_select_strap_i, // Strap
  input wire logic boost_en_o, // Boost on
  input wire logic [1:0] boost_voltage_setting_o, // Boost code
  input wire logic host_supply_regulator_en_o, // Host on
  input wire logic [1:0] host_supply_voltage_setting_o, // Host code
  input wire logic active_o, // Active
  input wire logic [2:0] state_o // State
);
  logic [2:0] st_q, st_d;
  int unsigned cnt_q, cnt_d;
  always_comb
  begin
    st_d = state_o;
    cnt_d = (state_o == st_q) ? cnt_q + 1 : 1;
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_q <= 3'h0;
      cnt_q <= 0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_at(logic [2:0] st);
    state_o == st && power_up_threshold_i;
  endsequence
  a_init_dwell: assert property (state_o == PUS_ST_BOOST_WAIT && st_q == PUS_ST_INIT |->
    cnt_q == INIT_CYCLES + 1) else $error("init phase length wrong");
  a_boost_start: assert property ($rose(boost_en_o) |-> $past(state_o) == PUS_ST_INIT &&
    boost_voltage_setting_o == PUS_BOOST_3V8) else $error("boost start wrong");
  a_boost_gate: assert property (s_at(PUS_ST_BOOST_WAIT) |=> state_o ==
    ($past(boost_pg_i) ? PUS_ST_STRAP : PUS_ST_BOOST_WAIT)) else $error("boost wait wrong");
  a_strap_dwell: assert property (state_o == PUS_ST_LOAD && st_q == PUS_ST_STRAP |->
    cnt_q == STRAP_CYCLES + 1) else $error("strap window length wrong");
  a_strap_decode: assert property (s_at(PUS_ST_LOAD) |=>
    host_supply_voltage_setting_o == $past(supply_select_strap_i, 2) &&
    boost_voltage_setting_o == ($past(supply_select_strap_i, 2) == 2'h3 ? PUS_BOOST_4V7 :
    $past(supply_select_strap_i, 2) == 2'h2 ? PUS_BOOST_3V8 : PUS_BOOST_2V7))
    else $error("strap decode wrong");
  a_host_gate: assert property (s_at(PUS_ST_BOOST_WAIT2) |=>
    host_supply_regulator_en_o == $past(boost_pg_i)) else $error("host enable wrong");
  a_active_gate: assert property (s_at(PUS_ST_HOST_WAIT) |=>
    active_o == $past(host_pg_i)) else $error("active entry wrong");
  a_supply_loss: assert property (!power_up_threshold_i |=> state_o == PUS_ST_OFF &&
    !boost_en_o && !host_supply_regulator_en_o && !active_o) else $error("supply loss wrong");
endmodule
bind pus_sequencer pus_sequencer_sva #(.INIT_CYCLES(INIT_CYCLES), .STRAP_CYCLES(STRAP_CYCLES))
  u_sva (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .power_up_threshold_i(power_up_threshold_i),
  .boost_pg_i(boost_pg_i), .host_pg_i(host_pg_i), .supply_select_strap_i(supply_select_strap_i),
  .boost_en_o(boost_en_o), .boost_voltage_setting_o(boost_voltage_setting_o),
  .host_supply_regulator_en_o(host_supply_regulator_en_o), .active_o(active_o),
  .host_supply_voltage_setting_o(host_supply_voltage_setting_o), .state_o(state_o));
`default_nettype wire

//--- pus_pg_model.sv
// Purpose: Power-good comparators behind the regulator enables
// Assumes: Ramp delay changes only while both enables are low
// Notes:   A disabled rail, or a new boost target, loses power-good at once, except a boost rail held good by ext_i
`timescale 1ns/1ps
`default_nettype none
module pus_pg_model (
  input wire logic clk_sys_i, // Clock
  input wire logic rst_n_i, // Reset
  input wire logic boost_en_i, // Boost on
  input wire logic host_en_i, // Host on
  input wire logic [1:0] boost_set_i, // Boost target code
  input wire logic ext_i, // Rail fed externally
  input wire logic [3:0] dly_i, // Ramp cycles
  output logic boost_pg_o, // Boost good
  output logic host_pg_o // Host good
);
  logic [3:0] b_q, h_q;
  logic [1:0] s_q;
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      b_q <= 4'h0;
      h_q <= 4'h0;
      s_q <= 2'h0;
    end
    else
    begin
      // A changed target restarts the ramp, so the second boost wait really waits
      b_q <= (boost_en_i && s_q == boost_set_i) ? b_q + {3'h0, b_q != dly_i} : 4'h0;
      h_q <= host_en_i ? h_q + {3'h0, h_q != dly_i} : 4'h0;
      s_q <= boost_set_i;
    end
  end
  // External supply keeps the boost rail good without the converter
  assign boost_pg_o = ext_i | (boost_en_i & (b_q == dly_i) & (s_q == boost_set_i));
  assign host_pg_o = host_en_i & (h_q == dly_i);
endmodule
`default_nettype wire

//--- pus_sequencer_tb.sv
// Purpose: Self-checking bench for the power-up sequencer
// Assumes: Shortened init and strap counts
// Notes:   Ramp delays are random from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module pus_sequencer_tb
  import pus_pkg::*;
;
  localparam int unsigned N_INIT = 20;
  logic clk_sys_i = 1'b0, rst_n_i = 1'b0, thr = 1'b0, ext = 1'b0;
  logic [1:0] strap = 2'h0, bset, hset;
  logic [3:0] dly = 4'h0;
  logic boost_pg, host_pg, boost_en, host_en, active;
  logic [2:0] state;
  logic [31:0] lfsr = 32'hb00e8d50;
  int miscompares = 0, total_checks = 0;
  initial forever #20 clk_sys_i = ~clk_sys_i;
  pus_sequencer #(.INIT_CYCLES(N_INIT), .STRAP_CYCLES(10)) u_pus_sequencer (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .power_up_threshold_i(thr),
    .boost_pg_i(boost_pg), .host_pg_i(host_pg), .supply_select_strap_i(strap),
    .boost_en_o(boost_en), .boost_voltage_setting_o(bset), .host_supply_regulator_en_o(host_en),
    .host_supply_voltage_setting_o(hset), .active_o(active), .state_o(state));
  pus_pg_model u_pus_pg_model (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .boost_en_i(boost_en),
    .host_en_i(host_en), .boost_set_i(bset), .ext_i(ext), .dly_i(dly), .boost_pg_o(boost_pg),
    .host_pg_o(host_pg));
  function automatic logic [31:0] next_rand(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [3:0] exp_set(input logic [1:0] s);
    case (s)
      2'h0: return {PUS_BOOST_2V7, PUS_HOST_1V5};
      2'h1: return {PUS_BOOST_2V7, PUS_HOST_1V8};
      2'h2: return {PUS_BOOST_3V8, PUS_HOST_2V5};
      default: return {PUS_BOOST_4V7, PUS_HOST_3V3};
    endcase
  endfunction
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic run(input logic [1:0] s, input logic e, input logic [2:0] stop);
    int i;
    lfsr = next_rand(lfsr);
    dly = lfsr[3:0];
    ext = e;
    strap = s;
    thr = 1'b1;
    repeat (N_INIT + 1) @(negedge clk_sys_i);
    chk({boost_en, host_en, active, 1'b0}, 4'h0);
    @(negedge clk_sys_i);
    chk({boost_en, bset, host_en}, {1'b1, PUS_BOOST_3V8, 1'b0});
    for (i = 0; i < 200 && !(active === 1'b1) && state !== stop; i++)
      @(negedge clk_sys_i);
    if (i == 200)
    begin
      miscompares++;
      summarize();
    end
    if (stop == PUS_ST_ACTIVE)
      chk({bset, hset}, exp_set(s));
    chk({boost_en, host_en, active, 1'b0}, {2'h3, stop == PUS_ST_ACTIVE, 1'b0});
    thr = 1'b0;
    @(negedge clk_sys_i);
    chk({boost_en, host_en, active, state !== PUS_ST_OFF}, 4'h0);
    chk({bset, hset}, {PUS_BOOST_RESET, PUS_HOST_RESET});
    @(negedge clk_sys_i);
  endtask
  initial
  begin
    repeat (4) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    @(negedge clk_sys_i);
    chk({boost_en, bset, host_en}, {1'b0, PUS_BOOST_RESET, 1'b0});
    for (int k = 0; k < 4; k++)
      run(k[1:0], 1'b0, PUS_ST_ACTIVE);
    run(lfsr[5:4], 1'b1, PUS_ST_ACTIVE);
    run(lfsr[7:6], 1'b0, PUS_ST_HOST_WAIT);
    summarize();
  end
endmodule
`default_nettype wire
